// >>> inc/sdbg_pkg.sv
// constants and types for the single-wire debug command block
`default_nettype none
package sdbg_pkg;
  // clock and serial timing
  localparam int CLK_HZ       = 25_000_000;
  // fast enough that a full register dump stays short
  localparam int LINK_BAUD    = 1_000_000;
  localparam int BIT_CYCLES   = CLK_HZ / LINK_BAUD;
  localparam int HALF_CYCLES  = BIT_CYCLES / 2;
  localparam int CNT_W        = 16;
  localparam int FRAME_BITS   = 10;

  // command opcodes
  localparam logic [7:0] OP_READ_REV   = 8'h00;
  localparam logic [7:0] OP_READ_STAT  = 8'h01;
  localparam logic [7:0] OP_READ_CTL   = 8'h02;
  localparam logic [7:0] OP_WRITE_CTL  = 8'h03;
  localparam logic [7:0] OP_READ_REGS  = 8'h04;
  localparam logic [7:0] OP_WRITE_REGS = 8'h05;
  localparam logic [7:0] REG_BYTES     = 8'h40;

  // packet check byte
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;

  // revision identifier, value arbitrary
  localparam logic [15:0] REV_ID = 16'h0a51;

  // register indices; byte address is four times the index
  localparam logic [31:0] IDX_TRACE  = 32'h00ff_e013;
  localparam logic [31:0] IDX_CTL    = 32'h00ff_e014;
  localparam logic [31:0] IDX_STAT   = 32'h00ff_e015;
  localparam logic [31:0] IDX_BKPT   = 32'h00ff_e016;
  localparam logic [31:0] IDX_REV    = 32'h00ff_e017;
  localparam logic [31:0] ADDR_TRACE = IDX_TRACE << 2;
  localparam logic [31:0] ADDR_CTL   = IDX_CTL << 2;
  localparam logic [31:0] ADDR_STAT  = IDX_STAT << 2;
  localparam logic [31:0] ADDR_BKPT  = IDX_BKPT << 2;
  localparam logic [31:0] ADDR_REV   = IDX_REV << 2;

  // trace control fields
  localparam int         TRACE_EN_BIT   = 7;
  localparam int         TRACE_SEL_LSB  = 0;
  localparam int         TRACE_SEL_W    = 3;
  localparam logic [7:0] TRACE_RW_MASK  = 8'h87;
  localparam logic [7:0] TRACE_RESET    = 8'h00;
  localparam logic [11:0] TRACE_EVENTS0 = 12'h010;
  localparam logic [14:0] TRACE_BYTES0  = 15'h0080;

  // debug control and status fields
  localparam int         CTL_BKPT_EN_BIT = 0;
  localparam logic [7:0] CTL_RESET       = 8'h00;
  localparam int         STAT_OPEN_BIT   = 0;
  localparam int         STAT_TRACE_BIT  = 1;
  localparam int         STAT_BKPT_BIT   = 2;
  localparam logic [23:0] BKPT_RESET     = 24'h00_0000;

  typedef enum logic [1:0] {RX_IDLE, RX_BITS} sdbg_rx_t;
  typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_START, TX_BITS} sdbg_tx_t;
  typedef enum logic [2:0] {
    C_LOCKED, C_IDLE, C_WRCTL, C_WRREG, C_SEND, C_WAITTX
  } sdbg_cmd_t;

  typedef struct packed {
    logic [3:0]  sel;
    logic [31:0] wdata;
    logic        wr;
  } sdbg_cpu_reg_t;

  typedef struct packed {
    logic        en;
    logic [2:0]  size;
    logic [11:0] events;
    logic [14:0] bytes;
  } sdbg_trace_t;
endpackage
`default_nettype wire

// >>> rtl/sdbg_core.sv
// single-wire debug command interpreter with apb register slave
`default_nettype none

module sdbg_core
  import sdbg_pkg::*;
(
  input  wire logic          clk_in,
  input  wire logic          rst_n_in,
  input  wire logic          psel_in,
  input  wire logic          penable_in,
  input  wire logic          pwrite_in,
  input  wire logic [31:0]   paddr_in,
  input  wire logic [31:0]   pwdata_in,
  output logic      [31:0]   prdata_out,
  output logic               pready_out,
  output logic               pslverr_out,
  input  wire logic          debug_line_in,
  output logic               debug_line_out,
  output logic               debug_line_oe_out,
  input  wire logic [23:0]   cpu_addr_in,
  input  wire logic [31:0]   cpu_reg_rdata_in,
  output sdbg_cpu_reg_t      cpu_reg_out,
  output logic               breakpoint_out,
  output sdbg_trace_t        trace_out,
  output logic      [7:0]    debug_control_out
);

  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++)
    begin
      r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // ****************************************
  // line sampling and receiver
  // ****************************************
  sdbg_rx_t         rx_state;
  sdbg_tx_t         tx_state;
  logic             line_q;
  logic             fall;
  logic [CNT_W-1:0] rx_cnt;
  logic [3:0]       rx_bit;
  logic [8:0]       rx_shift;
  logic             rx_valid;
  logic [7:0]       rx_byte;

  assign fall = line_q & ~debug_line_in;

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      line_q <= 1'b1;
    else
      line_q <= debug_line_in;
  end

  // receiver only listens while we are not answering, so the host's
  // flow-control start bit is never taken for a command byte
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rx_state <= RX_IDLE;
      rx_cnt   <= '0;
      rx_bit   <= '0;
      rx_shift <= '0;
      rx_valid <= 1'b0;
      rx_byte  <= '0;
    end
    else
    begin
      rx_valid <= 1'b0;
      unique case (rx_state)
        RX_IDLE:
        begin
          if (fall && tx_state == TX_IDLE)
          begin
            rx_state <= RX_BITS;
            rx_cnt   <= CNT_W'(HALF_CYCLES);
            rx_bit   <= '0;
          end
        end
        RX_BITS:
        begin
          if (rx_cnt != '0)
            rx_cnt <= rx_cnt - 1'b1;
          else
          begin
            rx_cnt <= CNT_W'(BIT_CYCLES - 1);
            rx_bit <= rx_bit + 1'b1;
            if (rx_bit == 4'd0 && debug_line_in)
              rx_state <= RX_IDLE;
            else if (rx_bit == 4'(FRAME_BITS))
            begin
              rx_state <= RX_IDLE;
              // space parity doubles as acknowledge; stop bit must be high
              if (!rx_shift[8] && debug_line_in)
              begin
                rx_valid <= 1'b1;
                rx_byte  <= rx_shift[7:0];
              end
            end
            else if (rx_bit != 4'd0)
              rx_shift <= {debug_line_in, rx_shift[8:1]};
          end
        end
        default:
          rx_state <= RX_IDLE;
      endcase
    end
  end

  // ****************************************
  // transmitter with start-bit flow control
  // ****************************************
  logic             tx_go;
  logic [7:0]       tx_data;
  logic [CNT_W-1:0] tx_cnt;
  logic [3:0]       tx_bit;
  logic [9:0]       tx_shift;
  logic             tx_done;

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      tx_state          <= TX_IDLE;
      tx_cnt            <= '0;
      tx_bit            <= '0;
      tx_shift          <= '0;
      tx_done           <= 1'b0;
      debug_line_out    <= 1'b1;
      debug_line_oe_out <= 1'b0;
    end
    else
    begin
      tx_done <= 1'b0;
      unique case (tx_state)
        TX_IDLE:
        begin
          if (tx_go)
          begin
            tx_state <= TX_WAIT;
            // stop high, parity held at zero, data lsb first
            tx_shift <= {1'b1, 1'b0, tx_data};
          end
        end
        TX_WAIT:
        begin
          // hold off until the host sends its start bit
          if (fall)
          begin
            tx_state <= TX_START;
            tx_cnt   <= CNT_W'(BIT_CYCLES - 2);
          end
        end
        TX_START:
        begin
          if (tx_cnt != '0)
            tx_cnt <= tx_cnt - 1'b1;
          else
          begin
            tx_state          <= TX_BITS;
            tx_cnt            <= CNT_W'(BIT_CYCLES - 1);
            tx_bit            <= '0;
            debug_line_out    <= tx_shift[0];
            debug_line_oe_out <= 1'b1;
            tx_shift          <= {1'b1, tx_shift[9:1]};
          end
        end
        TX_BITS:
        begin
          if (tx_cnt != '0)
            tx_cnt <= tx_cnt - 1'b1;
          else if (tx_bit == 4'(FRAME_BITS - 1))
          begin
            tx_state          <= TX_IDLE;
            tx_done           <= 1'b1;
            debug_line_out    <= 1'b1;
            debug_line_oe_out <= 1'b0;
          end
          else
          begin
            tx_cnt         <= CNT_W'(BIT_CYCLES - 1);
            tx_bit         <= tx_bit + 1'b1;
            debug_line_out <= tx_shift[0];
            tx_shift       <= {1'b1, tx_shift[9:1]};
          end
        end
        default:
          tx_state <= TX_IDLE;
      endcase
    end
  end

  // ****************************************
  // command interpreter
  // ****************************************
  sdbg_cmd_t  cmd_state;
  logic [7:0] opcode;
  logic [7:0] idx;
  logic [7:0] resp_len;
  logic       with_crc;
  logic       rev_seen;
  logic [7:0] crc;
  logic [7:0] resp_byte;
  logic [7:0] data_byte;
  logic [7:0] next_idx;
  logic [1:0] byte_lane;
  logic       cmd_ctl_wr;
  logic [7:0] cmd_ctl_data;
  logic [7:0] debug_status_reg;
  logic [7:0] debug_control_reg;
  logic [7:0] trace_control_reg;
  logic [3:0] reg_sel;
  logic [31:0] reg_wdata;
  logic       reg_wr;

  assign next_idx = idx + 8'h01;
  // kept at two bits so the inversion is not widened before it applies
  assign byte_lane = ~idx[1:0];

  always_comb
  begin
    unique case (opcode)
      OP_READ_REV:  data_byte = (idx == 8'h00) ? REV_ID[15:8] : REV_ID[7:0];
      OP_READ_STAT: data_byte = debug_status_reg;
      OP_READ_CTL:  data_byte = debug_control_reg;
      OP_READ_REGS: data_byte = cpu_reg_rdata_in[{byte_lane, 3'b000} +: 8];
      default:      data_byte = 8'h00;
    endcase
    resp_byte = (idx == resp_len) ? crc : data_byte;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cmd_state    <= C_LOCKED;
      opcode       <= '0;
      idx          <= '0;
      resp_len     <= '0;
      with_crc     <= 1'b0;
      rev_seen     <= 1'b0;
      crc          <= CRC_INIT;
      tx_go        <= 1'b0;
      tx_data      <= '0;
      cmd_ctl_wr   <= 1'b0;
      cmd_ctl_data <= '0;
      reg_sel      <= '0;
      reg_wdata    <= '0;
      reg_wr       <= 1'b0;
    end
    else
    begin
      tx_go      <= 1'b0;
      cmd_ctl_wr <= 1'b0;
      reg_wr     <= 1'b0;
      unique case (cmd_state)
        C_LOCKED, C_IDLE:
        begin
          // until the first revision request every byte is dropped
          if (rx_valid && (cmd_state == C_IDLE || rx_byte == OP_READ_REV))
          begin
            opcode   <= rx_byte;
            idx      <= '0;
            crc      <= crc8(CRC_INIT, rx_byte);
            rev_seen <= rev_seen | (rx_byte == OP_READ_REV);
            with_crc <= 1'b1;
            reg_sel  <= 4'hf;
            unique case (rx_byte)
              OP_READ_REV:
              begin
                cmd_state <= C_SEND;
                resp_len  <= 8'h02;
                with_crc  <= rev_seen;
              end
              OP_READ_STAT, OP_READ_CTL:
              begin
                cmd_state <= C_SEND;
                resp_len  <= 8'h01;
              end
              OP_WRITE_CTL:
                cmd_state <= C_WRCTL;
              OP_READ_REGS:
              begin
                cmd_state <= C_SEND;
                resp_len  <= REG_BYTES;
              end
              OP_WRITE_REGS:
                cmd_state <= C_WRREG;
              default:
                cmd_state <= C_IDLE;
            endcase
          end
        end
        C_WRCTL:
        begin
          if (rx_valid)
          begin
            cmd_ctl_wr   <= 1'b1;
            cmd_ctl_data <= rx_byte;
            crc          <= crc8(crc, rx_byte);
            resp_len     <= 8'h00;
            cmd_state    <= C_SEND;
          end
        end
        C_WRREG:
        begin
          if (rx_valid)
          begin
            crc       <= crc8(crc, rx_byte);
            reg_wdata <= {reg_wdata[23:0], rx_byte};
            idx       <= next_idx;
            if (idx[1:0] == 2'b11)
            begin
              reg_wr  <= 1'b1;
              reg_sel <= ~idx[5:2];
            end
            if (next_idx == REG_BYTES)
            begin
              idx       <= '0;
              resp_len  <= 8'h00;
              cmd_state <= C_SEND;
            end
          end
        end
        C_SEND:
        begin
          if (idx == resp_len && !with_crc)
            cmd_state <= C_IDLE;
          else if (tx_state == TX_IDLE)
          begin
            tx_go     <= 1'b1;
            tx_data   <= resp_byte;
            cmd_state <= C_WAITTX;
            if (idx != resp_len)
              crc <= crc8(crc, resp_byte);
          end
        end
        C_WAITTX:
        begin
          if (tx_done)
          begin
            if (idx == resp_len)
              cmd_state <= C_IDLE;
            else
            begin
              idx       <= next_idx;
              reg_sel   <= ~next_idx[5:2];
              cmd_state <= C_SEND;
            end
          end
        end
        default:
          cmd_state <= C_IDLE;
      endcase
    end
  end

  assign cpu_reg_out.sel   = reg_sel;
  assign cpu_reg_out.wdata = reg_wdata;
  assign cpu_reg_out.wr    = reg_wr;

  // ****************************************
  // apb slave and register file
  // ****************************************
  logic        apb_ready;
  logic        apb_wr;
  logic        hit;
  logic [31:0] rd_mux;
  logic [23:0] bkpt_addr;
  logic        bkpt_sticky;

  // one wait state so read data comes straight from a flop
  assign pready_out = apb_ready;
  assign apb_wr     = psel_in & penable_in & pwrite_in & apb_ready;

  always_comb
  begin
    hit    = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (paddr_in)
      ADDR_TRACE: rd_mux = {24'h00_0000, trace_control_reg};
      ADDR_CTL:   rd_mux = {24'h00_0000, debug_control_reg};
      ADDR_STAT:  rd_mux = {24'h00_0000, debug_status_reg};
      ADDR_BKPT:  rd_mux = {8'h00, bkpt_addr};
      ADDR_REV:   rd_mux = {16'h0000, REV_ID};
      default:    hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      apb_ready   <= 1'b0;
      prdata_out  <= '0;
      pslverr_out <= 1'b0;
    end
    else
    begin
      apb_ready   <= psel_in & penable_in & ~apb_ready;
      pslverr_out <= psel_in & penable_in & ~apb_ready & ~hit;
      if (psel_in && penable_in && !apb_ready && !pwrite_in)
        prdata_out <= rd_mux;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      trace_control_reg <= TRACE_RESET;
    else if (apb_wr && paddr_in == ADDR_TRACE)
      // reserved bits stay zero whatever is written
      trace_control_reg <= pwdata_in[7:0] & TRACE_RW_MASK;
  end

  // the debug line's write wins over a same-cycle bus write
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      debug_control_reg <= CTL_RESET;
    else if (cmd_ctl_wr)
      debug_control_reg <= cmd_ctl_data;
    else if (apb_wr && paddr_in == ADDR_CTL)
      debug_control_reg <= pwdata_in[7:0];
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      bkpt_addr <= BKPT_RESET;
    else if (apb_wr && paddr_in == ADDR_BKPT)
      bkpt_addr <= pwdata_in[23:0];
  end

  // ****************************************
  // breakpoint and trace
  // ****************************************
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      breakpoint_out <= 1'b0;
      bkpt_sticky    <= 1'b0;
    end
    else
    begin
      breakpoint_out <= debug_control_reg[CTL_BKPT_EN_BIT]
                        & (cpu_addr_in == bkpt_addr);
      // a new hit outranks a clear in the same cycle
      if (breakpoint_out)
        bkpt_sticky <= 1'b1;
      else if (apb_wr && paddr_in == ADDR_STAT && pwdata_in[STAT_BKPT_BIT])
        bkpt_sticky <= 1'b0;
    end
  end

  always_comb
  begin
    debug_status_reg                 = 8'h00;
    debug_status_reg[STAT_OPEN_BIT]  = rev_seen;
    debug_status_reg[STAT_TRACE_BIT] = trace_control_reg[TRACE_EN_BIT];
    debug_status_reg[STAT_BKPT_BIT]  = bkpt_sticky;
  end

  assign debug_control_out = debug_control_reg;
  assign trace_out.en      = trace_control_reg[TRACE_EN_BIT];
  assign trace_out.size    = trace_control_reg[TRACE_SEL_LSB +: TRACE_SEL_W];
  assign trace_out.events  = TRACE_EVENTS0 << trace_out.size;
  assign trace_out.bytes   = TRACE_BYTES0 << trace_out.size;

endmodule
`default_nettype wire

// >>> tb/sdbg_core_props.sv
// concurrent checks on the ports of the debug command block
`default_nettype none
module sdbg_core_props
  import sdbg_pkg::*;
(
  input wire logic          clk_in,
  input wire logic          rst_n_in,
  input wire logic          psel_in,
  input wire logic          penable_in,
  input wire logic          pwrite_in,
  input wire logic [31:0]   paddr_in,
  input wire logic [31:0]   pwdata_in,
  input wire logic [31:0]   prdata_out,
  input wire logic          pready_out,
  input wire logic          pslverr_out,
  input wire logic          debug_line_in,
  input wire logic          debug_line_out,
  input wire logic          debug_line_oe_out,
  input wire logic [23:0]   cpu_addr_in,
  input wire logic [31:0]   cpu_reg_rdata_in,
  input wire sdbg_cpu_reg_t cpu_reg_out,
  input wire logic          breakpoint_out,
  input wire sdbg_trace_t   trace_out,
  input wire logic [7:0]    debug_control_out
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PAR_LO  = 8 * BIT_CYCLES;
  localparam int STOP_LO = 9 * BIT_CYCLES;
  localparam int FRAME_C = FRAME_BITS * BIT_CYCLES;
  logic [CNT_W-1:0] oe_cnt;
  wire logic        hit = psel_in & penable_in & pready_out & (paddr_in == ADDR_TRACE);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // cycles the device has driven the wire in the current character
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      oe_cnt <= '0;
    else if (debug_line_oe_out)
      oe_cnt <= oe_cnt + 1'b1;
    else
      oe_cnt <= '0;
  end
  // ********
  // properties
  // ********
  property p_apb_wait;
    psel_in && $rose(penable_in) |-> !pready_out ##1 pready_out;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("apb wait state wrong");
  property p_err_rdy;
    pslverr_out |-> pready_out;
  endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("error without ready");
  property p_bkpt;
    breakpoint_out |-> $past(debug_control_out[CTL_BKPT_EN_BIT]);
  endproperty
  a_bkpt: assert property (p_bkpt) else $error("breakpoint while disabled");
  property p_events;
    trace_out.events == (TRACE_EVENTS0 << trace_out.size);
  endproperty
  a_events: assert property (p_events) else $error("trace event count wrong");
  property p_bytes;
    trace_out.bytes == (TRACE_BYTES0 << trace_out.size);
  endproperty
  a_bytes: assert property (p_bytes) else $error("trace byte size wrong");
  property p_en;
    $changed(trace_out.en) |-> $past(hit) && $past(pwrite_in);
  endproperty
  a_en: assert property (p_en) else $error("trace enable moved alone");
  property p_rd;
    hit && !pwrite_in |-> prdata_out == {24'h0, trace_out.en, 4'h0, trace_out.size};
  endproperty
  a_rd: assert property (p_rd) else $error("trace readback wrong");
  property p_len;
    $fell(debug_line_oe_out) |-> oe_cnt == FRAME_C;
  endproperty
  a_len: assert property (p_len) else $error("driven character length wrong");
  property p_par;
    debug_line_oe_out && oe_cnt >= PAR_LO && oe_cnt < STOP_LO |-> !debug_line_out;
  endproperty
  a_par: assert property (p_par) else $error("parity bit not space");
  property p_stop;
    debug_line_oe_out && oe_cnt >= STOP_LO |-> debug_line_out;
  endproperty
  a_stop: assert property (p_stop) else $error("stop bit not high");
  property p_wait;
    $rose(debug_line_oe_out) |-> !$past(debug_line_in, 8);
  endproperty
  a_wait: assert property (p_wait) else $error("drove without host start");
  c_char: cover property ($fell(debug_line_oe_out));
  c_bkpt: cover property (breakpoint_out);
  c_err: cover property (pslverr_out);
endmodule
bind sdbg_core sdbg_core_props u_props (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
  .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
  .debug_line_in(debug_line_in), .debug_line_out(debug_line_out),
  .debug_line_oe_out(debug_line_oe_out), .cpu_addr_in(cpu_addr_in),
  .cpu_reg_rdata_in(cpu_reg_rdata_in), .cpu_reg_out(cpu_reg_out),
  .breakpoint_out(breakpoint_out), .trace_out(trace_out),
  .debug_control_out(debug_control_out)
);
`default_nettype wire

// >>> tb/sdbg_host_model.sv
// debug host model: a serial port on the shared debug wire
`default_nettype none
module sdbg_host_model
  import sdbg_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic line_in,
  output var logic  drive_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // released means high: the wire has a pull-up
  initial drive_out = 1'b1;
  task automatic send_bit(input logic b);
    drive_out <= b;
    repeat (BIT_CYCLES) @(posedge clk_in);
  endtask
  task automatic take_bit(output logic b);
    b = line_in;
    repeat (BIT_CYCLES) @(posedge clk_in);
  endtask
  // lsb first, then a gap so the device sees idle
  task automatic send_byte(input logic [7:0] d);
    send_bit(1'b0);
    for (int i = 0; i < 8; i++) send_bit(d[i]);
    send_bit(1'b0);
    send_bit(1'b1);
    send_bit(1'b1);
  endtask
  // all-ones character: only its start bit is driven, a silent device leaves parity high
  task automatic recv_byte(output logic [9:0] v);
    send_bit(1'b0);
    drive_out <= 1'b1;
    repeat (HALF_CYCLES) @(posedge clk_in);
    for (int i = 0; i < 10; i++) take_bit(v[i]);
    repeat (BIT_CYCLES) @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

// >>> tb/single_wire_debug_commands_bench.sv
// self-checking bench for the debug command block
`default_nettype none
module single_wire_debug_commands_bench
  import sdbg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic          clk_in     = 1'b0;
  logic          rst_n      = 1'b0;
  logic          psel       = 1'b0;
  logic          penable    = 1'b0;
  logic          pwrite     = 1'b0;
  logic [31:0]   paddr      = 32'h0;
  logic [31:0]   pwdata     = 32'h0;
  logic [23:0]   cpu_addr   = 24'hff_ffff;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic          dl_out;
  logic          dl_oe;
  logic          host_drv;
  logic          bkpt;
  logic [7:0]    ctl;
  sdbg_cpu_reg_t cpu_reg;
  sdbg_trace_t   trace;
  logic [31:0]   cpu_regs [16];
  logic [31:0]   cpu_rdata;
  int            n_mismatch = 0;
  int            n_tests    = 0;
  wire logic     line       = dl_oe ? dl_out : host_drv;
  sdbg_core dut (
    .clk_in(clk_in), .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .debug_line_in(line),
    .debug_line_out(dl_out), .debug_line_oe_out(dl_oe), .cpu_addr_in(cpu_addr),
    .cpu_reg_rdata_in(cpu_rdata), .cpu_reg_out(cpu_reg), .breakpoint_out(bkpt),
    .trace_out(trace), .debug_control_out(ctl)
  );
  sdbg_host_model host (.clk_in(clk_in), .line_in(line), .drive_out(host_drv));
  always #20 clk_in = ~clk_in;
  // cpu register file behind the debug unit
  always @(posedge clk_in)
  begin
    if (cpu_reg.wr)
      cpu_regs[cpu_reg.sel] <= cpu_reg.wdata;
  end
  assign cpu_rdata = cpu_regs[cpu_reg.sel];
  // ********
  // helpers
  // ********
  task automatic finish_test;
    $display("mismatches %0d, checks %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] x);
    n_tests++;
    if (g !== x)
    begin
      n_mismatch++;
      $display("MISMATCH at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] s;
    s = c ^ b;
    for (int i = 0; i < 8; i++) s = s[7] ? ((s << 1) ^ CRC_POLY) : (s << 1);
    return s;
  endfunction
  // request held until ready is seen at a rising edge
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      n_mismatch++;
      $display("MISMATCH at %0t: apb timeout", $time);
      finish_test;
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    cmp(r, x);
    cmp({31'h0, e}, 32'h0);
  endtask
  // one reply character: space parity, stop high
  task automatic chr(input logic [7:0] b);
    logic [9:0] v;
    host.recv_byte(v);
    cmp({22'h0, v}, {22'h0, 2'b10, b});
  endtask
  task automatic silent;
    logic [9:0] v;
    host.recv_byte(v);
    cmp({22'h0, v}, 32'h3ff);
  endtask
  // ********
  // scenarios
  // ********
  task automatic t_lock;
    rd(ADDR_TRACE, 32'h0);
    rd(ADDR_STAT, 32'h0);
    host.send_byte(OP_READ_STAT);
    silent;
  endtask
  task automatic t_rev;
    host.send_byte(OP_READ_REV);
    chr(REV_ID[15:8]);
    chr(REV_ID[7:0]);
    silent;
    rd(ADDR_STAT, 32'h1);
    host.send_byte(OP_READ_REV);
    chr(REV_ID[15:8]);
    chr(REV_ID[7:0]);
    chr(crc8(crc8(crc8(CRC_INIT, OP_READ_REV), REV_ID[15:8]), REV_ID[7:0]));
  endtask
  task automatic t_stat_ctl;
    host.send_byte(OP_READ_STAT);
    chr(8'h01);
    chr(crc8(crc8(CRC_INIT, OP_READ_STAT), 8'h01));
    host.send_byte(OP_WRITE_CTL);
    host.send_byte(8'h01);
    chr(crc8(crc8(CRC_INIT, OP_WRITE_CTL), 8'h01));
    cmp({24'h0, ctl}, 32'h1);
    host.send_byte(OP_READ_CTL);
    chr(8'h01);
    chr(crc8(crc8(CRC_INIT, OP_READ_CTL), 8'h01));
  endtask
  // reserved bits written as ones on purpose
  task automatic t_trace;
    for (int i = 0; i < 8; i++)
    begin
      wr(ADDR_TRACE, {24'h0, 1'b1, 4'hf, i[2:0]});
      rd(ADDR_TRACE, {24'h0, 1'b1, 4'h0, i[2:0]});
      cmp({20'h0, trace.events}, 32'h10 << i);
      cmp({17'h0, trace.bytes}, 32'h80 << i);
      cmp({31'h0, trace.en}, 32'h1);
    end
    wr(ADDR_TRACE, 32'h0);
    @(posedge clk_in);
    cmp({31'h0, trace.en}, 32'h0);
  endtask
  // only the upper address byte differs in the near miss
  task automatic t_bkpt;
    wr(ADDR_BKPT, 32'h0012_3456);
    cpu_addr <= 24'h02_3456;
    repeat (3) @(posedge clk_in);
    cmp({31'h0, bkpt}, 32'h0);
    cpu_addr <= 24'h12_3456;
    repeat (2) @(posedge clk_in);
    cmp({31'h0, bkpt}, 32'h1);
    cpu_addr <= 24'hff_ffff;
    rd(ADDR_STAT, 32'h5);
    wr(ADDR_STAT, 32'h4);
    rd(ADDR_STAT, 32'h1);
  endtask
  task automatic t_err;
    logic [31:0] r;
    logic        e;
    apb(1'b0, 32'h0000_0100, 32'h0, r, e);
    cmp(r, 32'h0);
    cmp({31'h0, e}, 32'h1);
    rd(ADDR_REV, {16'h0, REV_ID});
  endtask
  // every word differs in each nibble, so a swapped index or byte shows
  task automatic t_regs;
    logic [7:0]  c;
    logic [7:0]  b;
    logic [31:0] w;
    c = crc8(CRC_INIT, OP_WRITE_REGS);
    host.send_byte(OP_WRITE_REGS);
    for (int i = 15; i >= 0; i--)
    begin
      w = 32'h0f1e_2d3c ^ {8{i[3:0]}};
      for (int k = 3; k >= 0; k--)
      begin
        b = w[8*k +: 8];
        host.send_byte(b);
        c = crc8(c, b);
      end
    end
    chr(c);
    for (int i = 0; i < 16; i++)
      cmp(cpu_regs[i], 32'h0f1e_2d3c ^ {8{i[3:0]}});
    c = crc8(CRC_INIT, OP_READ_REGS);
    host.send_byte(OP_READ_REGS);
    for (int i = 15; i >= 0; i--)
    begin
      w = 32'h0f1e_2d3c ^ {8{i[3:0]}};
      for (int k = 3; k >= 0; k--)
      begin
        b = w[8*k +: 8];
        chr(b);
        c = crc8(c, b);
      end
    end
    chr(c);
  endtask
  initial
  begin
    repeat (3) @(posedge clk_in);
    rst_n <= 1'b1;
    t_lock;
    t_rev;
    t_stat_ctl;
    t_trace;
    t_bkpt;
    t_err;
    t_regs;
    finish_test;
  end
endmodule
`default_nettype wire
